// ===== rtl/dac_calibration_engine.sv
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// Contract
// (RQ1) each of eight channels: input, gain, zero
// (RQ2) writes with correction on recompute automatically
// (RQ3) gain coefficient spans 0.5 to 1.5
// (RQ4) signed zero offset -32768 to +32767
// (RQ5) one shared correction datapath, serialized
// (RQ6) enable bit: correct or pass through
// (RQ7) disabled: gain/zero writes only store
// (RQ8) code = in*(gain+2^15)/2^16 + zero
// (RQ9) channels 0-3 group A, 4-7 group B
// (RQ10) latched code is 16 bits per channel
// (RQ11) gain select bit chooses 6 or 4
// (RQ12) offset defaults per group and gain
// (RQ13) power-on gain 32768, zero 0, input 0
// (RQ14) single supply powers offset converters down
// (RQ15) gain unsigned, zero two's complement always
// (RQ16) format pin: binary low, two's complement high
// (RQ17) gain change reloads offset default
// (RQ18) saturate corrected code to 0..65535
// (RQ19) latch load only after pending correction
module dac_calibration_engine #(
    parameter logic [15:0] OFFSET_A_G6 = dac_cal_pkg::OFFSET_G6,
    parameter logic [15:0] OFFSET_A_G4 = dac_cal_pkg::OFFSET_G4,
    parameter logic [15:0] OFFSET_B_G6 = dac_cal_pkg::OFFSET_G6,
    parameter logic [15:0] OFFSET_B_G4 = dac_cal_pkg::OFFSET_G4
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_data_format_select,
    input  wire logic        i_single_supply,
    input  wire logic        i_latch_load_strobe_n,
    output logic [127:0]     o_latch_code,
    output logic [15:0]      o_offset_converter_code_a,
    output logic [15:0]      o_offset_converter_code_b,
    output logic             o_offset_power_down,
    output logic             o_gain_six,
    output logic             o_reference_b_sel_mask
);
    localparam int N = dac_cal_pkg::CHANNELS;

    typedef enum logic [2:0] {
        ENG_IDLE  = 3'b001,
        ENG_CALC  = 3'b010,
        ENG_WAIT  = 3'b100
    } eng_type;

    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdata;
        logic                 corr_en;
        logic                 gain_sel;
        logic [15:0]          off_a;
        logic [15:0]          off_b;
        logic [N-1:0][15:0]   input_reg;
        logic [N-1:0][15:0]   gain_reg;
        logic [N-1:0][15:0]   zero_reg;
        logic [N-1:0][15:0]   data_reg;
        logic [N-1:0][15:0]   latch;
        logic [N-1:0]         pending;
        eng_type              eng;
        logic [2:0]           cur;
        logic                 ld_prev;
        logic                 ld_wait;
    } state_type;

    state_type st;
    state_type next_st;

    logic [1:0]  pins;
    logic        fmt_s;
    logic        ld_n_s;
    logic        math_start;
    logic        math_done;
    logic [15:0] math_res;
    logic [15:0] in_bin;

    // ---------------------------------------------------------------
    // pin synchronisers and shared engine
    // ---------------------------------------------------------------
    dac_pin_sync #(.WIDTH(2)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_async   ({i_data_format_select, i_latch_load_strobe_n}),
        .o_sync    (pins)
    );
    assign fmt_s  = pins[1];
    assign ld_n_s = pins[0];

    // two's complement input is converted to offset binary ahead of the math [RQ16]
    assign in_bin = fmt_s ? (st.input_reg[st.cur] ^ dac_cal_pkg::SIGN_FLIP)
                          : st.input_reg[st.cur];
    assign math_start = (st.eng == ENG_CALC);

    dac_correction_math u_math (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_start   (math_start),
        .i_code    (in_bin),
        .i_gain    (st.gain_reg[st.cur]),
        .i_zero    (st.zero_reg[st.cur]),
        .o_done    (math_done),
        .o_result  (math_res)
    );

    // ---------------------------------------------------------------
    // register, engine and latch logic
    // ---------------------------------------------------------------
    logic       wr;
    logic       rd;
    logic [2:0] ch;
    logic [7:0] bank;
    logic [15:0] wval;
    logic       ld_fall;

    always_comb begin
        next_st = st;
        wr = i_wb_cyc && i_wb_stb && i_wb_we && !st.ack;
        rd = i_wb_cyc && i_wb_stb && !i_wb_we && !st.ack;
        ch = i_wb_adr[4:2];
        bank = i_wb_adr & dac_cal_pkg::ADDR_BANK_MASK;
        wval = st.rdata[15:0];
        wval = {i_wb_sel[1] ? i_wb_dat[15:8] : 8'h00, i_wb_sel[0] ? i_wb_dat[7:0] : 8'h00};
        next_st.ack = i_wb_cyc && i_wb_stb && !st.ack;
        next_st.rdata = 32'h00000000;

        // ---- engine: one channel at a time, lowest pending first [RQ5]
        case (st.eng)
            ENG_IDLE: begin
                for (int i = N - 1; i >= 0; i--) begin
                    if (st.pending[i]) begin
                        next_st.cur = 3'(i);
                        next_st.eng = ENG_CALC;
                    end
                end
            end
            ENG_CALC: begin
                next_st.pending[st.cur] = 1'b0;
                next_st.eng = ENG_WAIT;
            end
            ENG_WAIT: begin
                if (math_done) begin
                    next_st.data_reg[st.cur] = math_res; // [RQ2]
                    next_st.eng = ENG_IDLE;
                end
            end
            default: next_st.eng = ENG_IDLE;
        endcase

        // ---- bus writes; a new request sets pending after the engine clears it
        if (wr) begin
            if (i_wb_adr == dac_cal_pkg::ADDR_CONFIG) begin
                if (i_wb_sel[0]) begin
                    next_st.corr_en = i_wb_dat[dac_cal_pkg::CFG_CORR_EN_BIT]; // [RQ6]
                    next_st.gain_sel = i_wb_dat[dac_cal_pkg::CFG_GAIN_SEL_BIT]; // [RQ11]
                    if (i_wb_dat[dac_cal_pkg::CFG_GAIN_SEL_BIT] != st.gain_sel) begin
                        // reload trimmed default of the new gain [RQ17] [RQ12]
                        next_st.off_a = i_wb_dat[dac_cal_pkg::CFG_GAIN_SEL_BIT]
                                        ? OFFSET_A_G6 : OFFSET_A_G4;
                        next_st.off_b = i_wb_dat[dac_cal_pkg::CFG_GAIN_SEL_BIT]
                                        ? OFFSET_B_G6 : OFFSET_B_G4;
                    end
                end
            end else if (i_wb_adr == dac_cal_pkg::ADDR_OFFSET_A) begin
                next_st.off_a = wval;
            end else if (i_wb_adr == dac_cal_pkg::ADDR_OFFSET_B) begin
                next_st.off_b = wval;
            end else if (bank == dac_cal_pkg::ADDR_INPUT_0) begin
                next_st.input_reg[ch] = wval; // [RQ1]
                if (st.corr_en) begin
                    next_st.pending[ch] = 1'b1; // [RQ2]
                end else begin
                    // bypass: straight to the data register, two's complement flipped to offset binary when the format pin is high [RQ6]
                    next_st.data_reg[ch] = fmt_s ? (wval ^ dac_cal_pkg::SIGN_FLIP) : wval;
                end
            end else if (bank == dac_cal_pkg::ADDR_GAIN_0) begin
                next_st.gain_reg[ch] = wval; // [RQ1]
                next_st.pending[ch] = st.corr_en | st.pending[ch]; // [RQ7]
            end else if (bank == dac_cal_pkg::ADDR_ZERO_0) begin
                next_st.zero_reg[ch] = wval; // [RQ1]
                next_st.pending[ch] = st.corr_en | st.pending[ch]; // [RQ7]
            end else if (bank == dac_cal_pkg::ADDR_DATA_0) begin
                next_st.data_reg[ch] = wval;
            end
        end

        // ---- bus reads, unmapped reads return zero
        if (rd) begin
            if (i_wb_adr == dac_cal_pkg::ADDR_CONFIG) begin
                next_st.rdata = {30'h00000000, st.gain_sel, st.corr_en};
            end else if (i_wb_adr == dac_cal_pkg::ADDR_STATUS) begin
                next_st.rdata = {20'h00000, st.eng != ENG_IDLE, st.ld_wait,
                                 fmt_s, i_single_supply, st.pending};
            end else if (i_wb_adr == dac_cal_pkg::ADDR_OFFSET_A) begin
                next_st.rdata = {16'h0000, st.off_a};
            end else if (i_wb_adr == dac_cal_pkg::ADDR_OFFSET_B) begin
                next_st.rdata = {16'h0000, st.off_b};
            end else if (bank == dac_cal_pkg::ADDR_INPUT_0) begin
                next_st.rdata = {16'h0000, st.input_reg[ch]};
            end else if (bank == dac_cal_pkg::ADDR_GAIN_0) begin
                next_st.rdata = {16'h0000, st.gain_reg[ch]}; // [RQ7]
            end else if (bank == dac_cal_pkg::ADDR_ZERO_0) begin
                next_st.rdata = {16'h0000, st.zero_reg[ch]}; // [RQ7]
            end else if (bank == dac_cal_pkg::ADDR_DATA_0) begin
                next_st.rdata = {16'h0000, st.data_reg[ch]};
            end else if (bank == dac_cal_pkg::ADDR_LATCH_0) begin
                next_st.rdata = {16'h0000, st.latch[ch]};
            end
        end

        // ---- latch load: falling strobe, deferred while correction runs [RQ19]
        next_st.ld_prev = ld_n_s;
        ld_fall = st.ld_prev && !ld_n_s;
        if (ld_fall || st.ld_wait) begin
            if (st.pending == '0 && st.eng == ENG_IDLE) begin
                next_st.latch = st.data_reg; // [RQ10]
                next_st.ld_wait = 1'b0;
            end else begin
                next_st.ld_wait = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st <= '0;
            // synchroniser output starts low; matching it avoids a false load edge
            st.ld_prev <= 1'b0;
            st.eng <= ENG_IDLE;
            st.gain_sel <= 1'b1;
            st.off_a <= OFFSET_A_G6; // [RQ12]
            st.off_b <= OFFSET_B_G6;
            for (int i = 0; i < N; i++) begin
                st.gain_reg[i]  <= dac_cal_pkg::GAIN_RESET; // [RQ13]
                st.zero_reg[i]  <= dac_cal_pkg::ZERO_RESET;
                st.input_reg[i] <= dac_cal_pkg::INPUT_RESET;
            end
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign o_wb_ack = st.ack;
    assign o_wb_dat = st.rdata;
    assign o_latch_code = st.latch;
    assign o_offset_converter_code_a = st.off_a;
    assign o_offset_converter_code_b = st.off_b;
    assign o_offset_power_down = i_single_supply; // [RQ14]
    assign o_gain_six = st.gain_sel;
    // channels 4..7 (latch vector bits 64..127) use reference B [RQ9]
    assign o_reference_b_sel_mask = (dac_cal_pkg::GROUP_SPLIT == N / 2);
endmodule

// ===== rtl/dac_cal_pkg.sv
package dac_cal_pkg;
    // ---------------------------------------------------------------
    // geometry
    // ---------------------------------------------------------------
    localparam int CHANNELS      = 8;
    localparam int CODE_W        = 16;
    localparam int CH_W          = 3;
    localparam int GROUP_SPLIT   = 4;
    // ---------------------------------------------------------------
    // register map (word offsets, byte address = offset)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG    = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_OFFSET_A  = 8'h08;
    localparam logic [7:0] ADDR_OFFSET_B  = 8'h0C;
    localparam logic [7:0] ADDR_INPUT_0   = 8'h20;
    localparam logic [7:0] ADDR_GAIN_0    = 8'h40;
    localparam logic [7:0] ADDR_ZERO_0    = 8'h60;
    localparam logic [7:0] ADDR_DATA_0    = 8'h80;
    localparam logic [7:0] ADDR_LATCH_0   = 8'hA0;
    localparam logic [7:0] ADDR_BANK_MASK = 8'hE0;
    // ---------------------------------------------------------------
    // config fields
    // ---------------------------------------------------------------
    localparam int CFG_CORR_EN_BIT  = 0;
    localparam int CFG_GAIN_SEL_BIT = 1;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] GAIN_RESET   = 16'h8000;
    localparam logic [15:0] ZERO_RESET   = 16'h0000;
    localparam logic [15:0] INPUT_RESET  = 16'h0000;
    localparam logic [15:0] OFFSET_G6    = 16'h999A;
    localparam logic [15:0] OFFSET_G4    = 16'hAAAB;
    localparam logic [16:0] GAIN_BIAS    = 17'h08000;
    localparam logic [17:0] CODE_MAX     = 18'h0FFFF;
    localparam logic [15:0] SIGN_FLIP    = 16'h8000;
endpackage

// ===== rtl/dac_correction_math.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// shared multiply-add, one result per cycle, registered
// ---------------------------------------------------------------
module dac_correction_math (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic        i_start,
    input  wire logic [15:0] i_code,
    input  wire logic [15:0] i_gain,
    input  wire logic [15:0] i_zero,
    output logic             o_done,
    output logic [15:0]      o_result
);
    typedef struct packed {
        logic        done;
        logic [15:0] result;
    } state_type;

    state_type st;
    state_type next_st;
    logic [32:0] prod;
    logic [17:0] sum;

    always_comb begin
        next_st = st;
        // coefficient (gain + 2^15)/2^16 spans 0.5 to 1.5 [RQ3] [RQ8] [RQ15]
        prod = {17'h00000, i_code} * ({1'b0, i_gain} + dac_cal_pkg::GAIN_BIAS);
        // zero is two's complement, added after the scale [RQ4] [RQ8]
        // scaled code needs 17 bits: a full-scale input at gain 1.5 exceeds 16
        sum = {1'b0, prod[32:16]} + {{2{i_zero[15]}}, i_zero};
        next_st.done = i_start;
        if (i_start) begin
            // clamp instead of wrapping [RQ18]
            if (sum[17]) begin
                next_st.result = 16'h0000;
            end else if (sum > dac_cal_pkg::CODE_MAX) begin
                next_st.result = 16'hFFFF;
            end else begin
                next_st.result = sum[15:0];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st <= '0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_done   = st.done;
    assign o_result = st.result;
endmodule

// ===== rtl/dac_pin_sync.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// two-flop synchroniser for pin levels
// ---------------------------------------------------------------
module dac_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } state_type;

    state_type st;
    state_type next_st;

    always_comb begin
        next_st = st;
        next_st.meta = i_async;
        next_st.stable = st.meta;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st <= '0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_sync = st.stable;
endmodule

// ===== bench/dac_cal_checker.sv
`timescale 1ns/1ps
module dac_cal_checker #(
    parameter logic [15:0] OFFSET_A_G6 = 16'h0000,
    parameter logic [15:0] OFFSET_A_G4 = 16'h0000
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic         i_wb_cyc,
    input  wire logic         i_wb_stb,
    input  wire logic         i_wb_we,
    input  wire logic [7:0]   i_wb_adr,
    input  wire logic         i_single_supply,
    input  wire logic         i_latch_load_strobe_n,
    input  wire logic [31:0]  o_wb_dat,
    input  wire logic         o_wb_ack,
    input  wire logic [127:0] o_latch_code,
    input  wire logic [15:0]  o_offset_converter_code_a,
    input  wire logic         o_offset_power_down,
    input  wire logic         o_gain_six
);
    // ----
    // strobe-high run; pending work is far shorter than the saturated count
    // ----
    logic [5:0] quiet;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || !i_latch_load_strobe_n) begin
            quiet <= 6'h00;
        end else if (quiet != 6'h3F) begin
            quiet <= quiet + 6'h01;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    ack_next_edge_a: assert property (i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack missing one cycle after request");
    ack_cause_a: assert property ($rose(o_wb_ack) |-> $past(i_wb_stb))
        else $error("ack without request");
    rdata_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data outside ack cycle");
    unmapped_zero_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'hFC |-> o_wb_dat == 32'h0)
        else $error("unmapped read not zero");
    power_down_a: assert property (o_offset_power_down == i_single_supply)
        else $error("offset power down wrong");
    offset_reload_a: assert property ($changed(o_gain_six) |-> ##[0:2]
        o_offset_converter_code_a == (o_gain_six ? OFFSET_A_G6 : OFFSET_A_G4))
        else $error("offset code not reloaded on gain change");
    latch_quiet_a: assert property (quiet == 6'h3F |-> $stable(o_latch_code))
        else $error("latch changed without load strobe");
    cover property (o_wb_ack && i_wb_we);
    cover property ($changed(o_latch_code));
    cover property ($fell(o_gain_six));
    cover property ($rose(o_offset_power_down));
endmodule

bind dac_calibration_engine dac_cal_checker #(.OFFSET_A_G6(OFFSET_A_G6),
    .OFFSET_A_G4(OFFSET_A_G4)) u_chk (.i_ref_clk, .i_rst_n, .i_ce, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_single_supply, .i_latch_load_strobe_n, .o_wb_dat, .o_wb_ack,
    .o_latch_code, .o_offset_converter_code_a, .o_offset_power_down, .o_gain_six);

// ===== bench/dac_host_model.sv
`timescale 1ns/1ps
// ----
// classic single-cycle host; waits a bounded time for ack
// ----
module dac_host_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_wb_ack,
    input  wire logic [31:0] i_wb_rdat,
    output logic             o_wb_cyc,
    output logic             o_wb_stb,
    output logic             o_wb_we,
    output logic [7:0]       o_wb_adr,
    output logic [3:0]       o_wb_sel,
    output logic [31:0]      o_wb_wdat,
    output logic             o_timeout
);
    initial begin
        {o_wb_cyc, o_wb_stb, o_wb_we, o_timeout} = 4'h0;
        {o_wb_adr, o_wb_sel, o_wb_wdat} = 44'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] r);
        int n;
        @(posedge i_ref_clk);
        {o_wb_cyc, o_wb_stb, o_wb_we} <= {2'h3, w};
        {o_wb_adr, o_wb_sel, o_wb_wdat} <= {a, 4'h3, 16'h0000, d};
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (i_wb_ack !== 1'b1 && n < 32);
        if (i_wb_ack !== 1'b1) o_timeout <= 1'b1;
        r = i_wb_rdat[15:0];
        {o_wb_cyc, o_wb_stb} <= 2'h0;
        // released data is scrambled so nothing can lean on a stale value
        o_wb_wdat <= ~o_wb_wdat;
    endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] B_G6 = 16'h9995;
    localparam logic [15:0] B_G4 = 16'hAAA8;
    typedef struct packed {
        logic        chk;
        logic [15:0] val;
    } note_type;
    logic         clk, rst_n, ce, cyc, stb, we, ack, fmt, single, strobe_n, pdn, g6, tmo, refb;
    logic [7:0]   adr;
    logic [3:0]   sel;
    logic [31:0]  wdat, rdat;
    logic [127:0] latch, exp_latch;
    logic [15:0]  offs_a, offs_b, rv;
    logic [15:0]  xs [8];
    logic [15:0]  gs [8];
    logic [15:0]  zs [8];
    note_type     notes [$];
    note_type     cur;
    int           n_errors, checks_done, seed;

    dac_calibration_engine #(.OFFSET_B_G6(B_G6), .OFFSET_B_G4(B_G4)) uut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_data_format_select(fmt), .i_single_supply(single),
        .i_latch_load_strobe_n(strobe_n), .o_latch_code(latch),
        .o_offset_converter_code_a(offs_a), .o_offset_converter_code_b(offs_b),
        .o_offset_power_down(pdn), .o_gain_six(g6), .o_reference_b_sel_mask(refb));
    dac_host_model host (.i_ref_clk(clk), .i_wb_ack(ack), .i_wb_rdat(rdat), .o_wb_cyc(cyc),
        .o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr), .o_wb_sel(sel), .o_wb_wdat(wdat),
        .o_timeout(tmo));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ----
    // helpers
    // ----
    function automatic logic [7:0] at(input logic [7:0] base, input int ch);
        return base + 8'(ch * 4);
    endfunction
    function automatic logic [15:0] cor(input logic [15:0] xi, gi, zi);
        longint t;
        t = ((longint'(xi) * (longint'(gi) + 32768)) >>> 16) + longint'($signed(zi));
        return (t < 0) ? 16'h0000 : (t > 65535) ? 16'hFFFF : 16'(t);
    endfunction
    task automatic chk(input string what, input logic [127:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.xfer(1'b1, a, d, rv);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic c);
        notes.push_back('{c, e});
        host.xfer(1'b0, a, 16'h0000, rv);
    endtask
    task automatic settle;
        int n;
        n = 0;
        do begin
            rd(dac_cal_pkg::ADDR_STATUS, 16'h0000, 1'b0);
            n++;
        end while ((rv & 16'h08FF) != 16'h0000 && n < 40);
        if (n >= 40) chk("engine idle", 128'h0, 128'(rv & 16'h08FF));
    endtask
    task automatic load_latch;
        int n;
        for (int c = 0; c < 8; c++) exp_latch[16*c +: 16] = cor(xs[c], gs[c], zs[c]);
        strobe_n <= 1'b0;
        repeat (3) @(posedge clk);
        strobe_n <= 1'b1;
        n = 0;
        while (latch !== exp_latch && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk("latch code", exp_latch, latch);
    endtask
    task automatic stop_test;
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----
    // read monitor: oldest note against each read answer
    // ----
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (notes.size() == 0) begin
                chk("read note", 128'h1, 128'h0);
            end else begin
                cur = notes.pop_front();
                if (cur.chk) chk("read data", 128'(cur.val), 128'(rdat));
            end
        end
    end
    always @(posedge tmo) begin
        n_errors++;
        stop_test;
    end
    // ----
    // main sequence
    // ----
    initial begin
        seed = 32'h7A6C;
        {n_errors, checks_done} = 64'h0;
        {rst_n, ce, fmt, single, strobe_n} = 5'h09;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            rd(at(dac_cal_pkg::ADDR_GAIN_0, c), 16'h8000, 1'b1);
            rd(at(dac_cal_pkg::ADDR_ZERO_0, c), 16'h0000, 1'b1);
            rd(at(dac_cal_pkg::ADDR_INPUT_0, c), 16'h0000, 1'b1);
        end
        rd(dac_cal_pkg::ADDR_OFFSET_A, dac_cal_pkg::OFFSET_G6, 1'b1);
        rd(dac_cal_pkg::ADDR_OFFSET_B, B_G6, 1'b1);
        chk("gain six", 128'h1, 128'(g6));
        for (int c = 0; c < 8; c++) begin
            xs[c] = 16'($random(seed));
            wr(at(dac_cal_pkg::ADDR_INPUT_0, c), xs[c]);
            rd(at(dac_cal_pkg::ADDR_DATA_0, c), xs[c], 1'b1);
        end
        wr(at(dac_cal_pkg::ADDR_GAIN_0, 1), 16'h1234);
        wr(at(dac_cal_pkg::ADDR_ZERO_0, 1), 16'hF00D);
        rd(at(dac_cal_pkg::ADDR_GAIN_0, 1), 16'h1234, 1'b1);
        rd(at(dac_cal_pkg::ADDR_ZERO_0, 1), 16'hF00D, 1'b1);
        rd(at(dac_cal_pkg::ADDR_DATA_0, 1), xs[1], 1'b1);
        fmt <= 1'b1;
        repeat (4) @(posedge clk);
        wr(dac_cal_pkg::ADDR_INPUT_0, 16'h0001);
        rd(dac_cal_pkg::ADDR_DATA_0, 16'h8001, 1'b1);
        fmt <= 1'b0;
        repeat (4) @(posedge clk);
        wr(dac_cal_pkg::ADDR_CONFIG, 16'h0003);
        for (int c = 0; c < 8; c++) {xs[c], gs[c], zs[c]} = 48'({$random(seed), $random(seed)});
        {xs[5], gs[5], zs[5]} = 48'hFFFF_0000_0000;
        {xs[6], gs[6], zs[6]} = 48'hFFFF_FFFF_7FFF;
        {xs[7], gs[7], zs[7]} = 48'h0000_0000_8000;
        for (int c = 0; c < 8; c++) begin
            wr(at(dac_cal_pkg::ADDR_INPUT_0, c), xs[c]);
            wr(at(dac_cal_pkg::ADDR_GAIN_0, c), gs[c]);
            wr(at(dac_cal_pkg::ADDR_ZERO_0, c), zs[c]);
        end
        settle;
        for (int c = 0; c < 8; c++) begin
            rd(at(dac_cal_pkg::ADDR_DATA_0, c), cor(xs[c], gs[c], zs[c]), 1'b1);
        end
        chk("latch held", 128'h0, latch);
        load_latch;
        xs[2] = 16'($random(seed));
        wr(at(dac_cal_pkg::ADDR_INPUT_0, 2), xs[2]);
        load_latch;
        wr(dac_cal_pkg::ADDR_CONFIG, 16'h0001);
        repeat (2) @(posedge clk);
        chk("gain six", 128'h0, 128'(g6));
        rd(dac_cal_pkg::ADDR_OFFSET_A, dac_cal_pkg::OFFSET_G4, 1'b1);
        chk("offset b", 128'(B_G4), 128'(offs_b));
        chk("group b mask", 128'h1, 128'(refb));
        wr(dac_cal_pkg::ADDR_OFFSET_A, 16'h1357);
        rd(dac_cal_pkg::ADDR_OFFSET_A, 16'h1357, 1'b1);
        wr(dac_cal_pkg::ADDR_CONFIG, 16'h0003);
        rd(dac_cal_pkg::ADDR_OFFSET_A, dac_cal_pkg::OFFSET_G6, 1'b1);
        rd(8'hFC, 16'h0000, 1'b1);
        // a load pulse while the clock enable is low must not reach the latch
        xs[3] = 16'($random(seed));
        wr(at(dac_cal_pkg::ADDR_INPUT_0, 3), xs[3]);
        repeat (8) @(posedge clk);
        ce <= 1'b0;
        strobe_n <= 1'b0;
        repeat (6) @(posedge clk);
        strobe_n <= 1'b1;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        repeat (6) @(posedge clk);
        chk("latch frozen", exp_latch, latch);
        single <= 1'b1;
        repeat (2) @(posedge clk);
        chk("power down", 128'h1, 128'(pdn));
        single <= 1'b0;
        stop_test;
    end
endmodule
